// file: verilog/lcd_i2c_pkg.sv
// shared constants for the display driver serial front end
package lcd_i2c_pkg;
  // ==========================================================================
  // display ram geometry
  localparam logic [6:0] x_last = 7'h65;   // column 101
  localparam logic [3:0] y_last = 4'h8;    // bank 8
  localparam int n_cols = 102;
  localparam int n_banks = 9;
  // ==========================================================================
  // slave address, upper six bits fixed
  localparam logic [5:0] addr_hi = 6'h1e;
  // ==========================================================================
  // reset values of settings
  localparam logic set_pd_rst = 1'b1;
  localparam logic set_v_rst = 1'b0;
  localparam logic set_h_rst = 1'b0;
  localparam logic set_mx_rst = 1'b0;
  localparam logic set_my_rst = 1'b0;
  localparam logic set_do_rst = 1'b0;
  // ==========================================================================
  // master bit timing: scl quarter period in clk cycles
  localparam int quarter_ns = 1250;
  localparam int clk_ns = 20;
  localparam logic [7:0] quarter_cyc = 8'(quarter_ns / clk_ns);
  // ==========================================================================
  // apb register offsets of the controller
  localparam logic [7:0] reg_ctrl = 8'h00;   // [0] go [1] read [2] stop [3] start
  localparam logic [7:0] reg_txd = 8'h04;    // byte to send
  localparam logic [7:0] reg_stat = 8'h08;   // [0] busy [1] nack
  localparam logic [7:0] reg_rxd = 8'h0c;    // byte received
  localparam logic [7:0] reg_ackc = 8'h10;   // [0] master acks read byte
endpackage : lcd_i2c_pkg

// file: verilog/lcd_i2c_if.sv
// two-wire bus between the display driver and its master
interface lcd_i2c_if;
  logic scl_o;
  logic scl_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  logic scl;
  logic sda;
  // ==========================================================================
  // open drain with pull-up: any enabled low driver wins
  assign scl = ~(scl_oe & ~scl_o);
  assign sda = ~((sda_m_oe & ~sda_m_o) | (sda_s_oe & ~sda_s_o));
  modport master (output scl_o, output scl_oe, output sda_m_o, output sda_m_oe,
    input scl, input sda);
  modport slave (output sda_s_o, output sda_s_oe, input scl, input sda);
endinterface : lcd_i2c_if

// file: verilog/lcd_driver_i2c.sv
// display driver end: bus slave, command decoder, pointers and display ram

module lcd_driver_i2c (
  input wire logic clk,
  input wire logic arst_n,
  lcd_i2c_if.slave bus,
  input wire logic address_select_pin,
  input wire logic [6:0] rd_col,
  input wire logic [3:0] rd_bank,
  output logic [7:0] rd_byte,
  output logic [7:0] status_byte,
  output logic [6:0] x_ptr,
  output logic [3:0] y_ptr
);
  typedef enum logic [2:0] {st_idle, st_addr, st_ctrl, st_data, st_tx, st_skip} ph_t;
  typedef struct packed {
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic [1:0] sel_s;
    logic scl_d;
    logic sda_d;
    ph_t ph;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic in_ack;
    logic rd_ack;
    logic chain;
    logic dc;
    logic last_dc;
    logic [6:0] x;
    logic [3:0] y;
    logic pd, v, h, mx, my, dsp_d, dsp_e, trs, brs, bo;
    logic sda_oe;
    logic we;
    logic [6:0] we_col;
    logic [3:0] we_bank;
    logic [7:0] we_data;
  } st_t;
  st_t r, n;
  localparam int n_cols_c = lcd_i2c_pkg::n_cols;
  localparam int n_banks_c = lcd_i2c_pkg::n_banks;
  logic [7:0] ram [n_cols_c * n_banks_c];
  logic scl_rise, scl_fall, start_c, stop_c, scl_h, sda_h;

  function automatic logic [7:0] rev8(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      rev8[i] = b[7 - i];
    end
  endfunction : rev8

  function automatic logic [7:0] status_of(input st_t s);
    status_of = {s.pd, s.trs, s.brs, s.dsp_d, s.dsp_e, s.mx, s.my, s.bo};
  endfunction : status_of

  // ==========================================================================
  // bus event detection on synchronised lines
  assign scl_h = r.scl_s[1];
  assign sda_h = r.sda_s[1];
  assign scl_rise = scl_h & ~r.scl_d;
  assign scl_fall = ~scl_h & r.scl_d;
  assign start_c = scl_h & r.scl_d & r.sda_d & ~sda_h;
  assign stop_c = scl_h & r.scl_d & ~r.sda_d & sda_h;

  // next state
  always_comb begin
    n = r;
    n.scl_s = {r.scl_s[0], bus.scl};
    n.sda_s = {r.sda_s[0], bus.sda};
    n.sel_s = {r.sel_s[0], address_select_pin};   // strap pin, two flops
    n.scl_d = scl_h;
    n.sda_d = sda_h;
    n.we = 1'b0;
    if (start_c) begin
      n.ph = st_addr;
      n.bitn = 4'h0;
      n.in_ack = 1'b0;
      n.sda_oe = 1'b0;
    end else if (stop_c) begin
      n.ph = st_idle;
      n.sda_oe = 1'b0;
      n.in_ack = 1'b0;
    end else if (scl_rise && !r.in_ack && r.ph != st_idle && r.ph != st_skip) begin
      n.sh = {r.sh[6:0], sda_h & (r.ph != st_tx)};
      n.bitn = r.bitn + 4'h1;
    end else if (scl_rise && r.in_ack && r.ph == st_tx) begin
      n.rd_ack = ~sda_h;
    end else if (scl_fall) begin
      if (r.in_ack) begin
        // ack clock ended: release or begin next byte
        n.in_ack = 1'b0;
        n.bitn = 4'h0;
        n.sda_oe = 1'b0;
        if (r.ph == st_tx) begin
          if (r.rd_ack) begin
            n.sh = status_of(r);
            n.sda_oe = ~r.pd;   // status msb is the power down flag
          end else begin
            n.ph = st_skip;
          end
        end
      end else if (r.bitn == 4'h8) begin
        n.in_ack = 1'b1;
        case (r.ph)
          st_addr: begin
            if (r.sh[7:1] == {lcd_i2c_pkg::addr_hi, r.sel_s[1]}) begin
              n.sda_oe = 1'b1;
              n.ph = r.sh[0] ? st_tx : st_ctrl;
              n.chain = 1'b1;
              if (r.sh[0] && r.last_dc) begin
                n.ph = st_skip;
              end
            end else begin
              n.ph = st_skip;
              n.in_ack = 1'b0;
            end
          end
          st_ctrl: begin
            n.sda_oe = 1'b1;
            n.chain = r.sh[7];
            n.dc = r.sh[6];
            n.last_dc = r.sh[6];
            n.ph = st_data;
          end
          st_data: begin
            n.sda_oe = 1'b1;
            n.ph = r.chain ? st_ctrl : st_data;
            if (r.dc) begin
              n.we = 1'b1;
              n.we_col = r.mx ? 7'(lcd_i2c_pkg::x_last - r.x) : r.x;
              n.we_bank = r.y;
              n.we_data = r.bo ? rev8(r.sh) : r.sh;
              if (r.x == lcd_i2c_pkg::x_last && r.y == lcd_i2c_pkg::y_last) begin
                n.x = 7'h00;
                n.y = 4'h0;
              end else if (r.v) begin
                if (r.y == lcd_i2c_pkg::y_last) begin
                  n.y = 4'h0;
                  n.x = r.x + 7'h01;
                end else begin
                  n.y = r.y + 4'h1;
                end
              end else begin
                if (r.x == lcd_i2c_pkg::x_last) begin
                  n.x = 7'h00;
                  n.y = r.y + 4'h1;
                end else begin
                  n.x = r.x + 7'h01;
                end
              end
            end else begin
              if (r.sh[7]) begin
                if (!r.h) begin
                  n.x = r.sh[6:0];
                end
              end else if (r.sh[7:5] == 3'h1) begin
                n.mx = r.sh[4];
                n.my = r.sh[3];
                n.pd = r.sh[2];
                n.v = r.sh[1];
                n.h = r.sh[0];
              end else if (r.sh[7:4] == 4'h4 && !r.h) begin
                n.y = r.sh[3:0];
              end else if (r.sh[7:3] == 5'h01 && !r.h) begin
                n.dsp_d = r.sh[2];
                n.dsp_e = r.sh[0];
              end else if (r.sh[7:3] == 5'h01 && r.h) begin
                n.bo = r.sh[2];
                n.trs = r.sh[1];
                n.brs = r.sh[0];
              end
            end
          end
          st_tx: begin
            n.sda_oe = 1'b0;
          end
          default: n.ph = st_skip;
        endcase
      end
    end
    // drive transmit bits on falling scl
    if (scl_fall && !r.in_ack && r.ph == st_tx && r.bitn != 4'h8 && !start_c && !stop_c) begin
      n.sda_oe = ~r.sh[7];
    end
  end

  // state register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      r <= '0;
      r.scl_s <= 2'h3;
      r.sda_s <= 2'h3;
      r.scl_d <= 1'b1;
      r.sda_d <= 1'b1;
      r.ph <= st_idle;
      r.pd <= lcd_i2c_pkg::set_pd_rst;
      r.v <= lcd_i2c_pkg::set_v_rst;
      r.h <= lcd_i2c_pkg::set_h_rst;
      r.mx <= lcd_i2c_pkg::set_mx_rst;
      r.my <= lcd_i2c_pkg::set_my_rst;
      r.bo <= lcd_i2c_pkg::set_do_rst;
    end else begin
      r <= n;
    end
  end

  // display ram, no reset: contents undefined after power on
  always_ff @(posedge clk) begin
    if (r.we) begin
      ram[r.we_bank * n_cols_c + r.we_col] <= r.we_data;
    end
    rd_byte <= ram[rd_bank * n_cols_c + rd_col];
  end

  // registered outputs
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      status_byte <= 8'h00;
      x_ptr <= 7'h00;
      y_ptr <= 4'h0;
    end else begin
      status_byte <= status_of(r);
      x_ptr <= r.x;
      y_ptr <= r.y;
    end
  end
  assign bus.sda_s_o = 1'b0;
  assign bus.sda_s_oe = r.sda_oe;
endmodule : lcd_driver_i2c

// file: verilog/lcd_i2c_master.sv
// master end: apb controlled two-wire byte engine
module lcd_i2c_master (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  lcd_i2c_if.master bus
);
  typedef enum logic [2:0] {m_idle, m_start, m_bit, m_ack, m_stop} mst_t;
  typedef struct packed {
    mst_t st;
    logic [7:0] tq;
    logic [1:0] q;
    logic [3:0] bitn;
    logic [7:0] tx;
    logic [7:0] rx;
    logic rd, do_stop, do_start, ack_c, nack, busy;
    logic scl, sda;
    logic [1:0] sda_s;
    logic [31:0] prdata;
    logic pready;
  } m_t;
  m_t r, n;
  logic tick;
  assign tick = (r.tq == lcd_i2c_pkg::quarter_cyc);

  // next state: four quarters per scl period, change data sda in quarter 0, start and stop edges in quarter 2
  always_comb begin
    n = r;
    n.sda_s = {r.sda_s[0], bus.sda};
    n.tq = tick ? 8'h00 : r.tq + 8'h01;
    n.pready = 1'b0;
    // apb slave: one wait state, answer in access phase
    if (psel && penable && !r.pready) begin
      n.pready = 1'b1;
      n.prdata = 32'h0;
      if (pwrite) begin
        case (paddr)
          lcd_i2c_pkg::reg_ctrl: begin
            if (pwdata[0] && !r.busy) begin
              n.busy = 1'b1;
              n.rd = pwdata[1];
              n.do_stop = pwdata[2];
              n.do_start = pwdata[3];
              n.nack = 1'b0;
              n.st = pwdata[3] ? m_start : m_bit;
              n.q = 2'h0;
              n.bitn = 4'h0;
            end
          end
          lcd_i2c_pkg::reg_txd: n.tx = pwdata[7:0];
          lcd_i2c_pkg::reg_ackc: n.ack_c = pwdata[0];
          default: n.prdata = 32'h0;
        endcase
      end else begin
        case (paddr)
          lcd_i2c_pkg::reg_txd: n.prdata = {24'h0, r.tx};
          lcd_i2c_pkg::reg_stat: n.prdata = {30'h0, r.nack, r.busy};
          lcd_i2c_pkg::reg_rxd: n.prdata = {24'h0, r.rx};
          lcd_i2c_pkg::reg_ackc: n.prdata = {31'h0, r.ack_c};
          default: n.prdata = 32'h0;
        endcase
      end
    end
    if (tick) begin
      n.q = r.q + 2'h1;
      case (r.st)
        m_idle: n.q = 2'h0;
        m_start: begin
          case (r.q)
            2'h0: begin
              n.sda = 1'b1;
              n.scl = 1'b1;
            end
            2'h2: n.sda = 1'b0;
            2'h3: begin
              n.scl = 1'b0;
              n.st = m_bit;
            end
            default: n.sda = r.sda;
          endcase
        end
        m_bit: begin
          // change sda only while scl low
          case (r.q)
            2'h0: n.sda = r.rd ? 1'b1 : r.tx[3'(7 - r.bitn)];
            2'h1: n.scl = 1'b1;
            2'h2: n.rx = r.rd ? {r.rx[6:0], r.sda_s[1]} : r.rx;
            2'h3: begin
              n.scl = 1'b0;
              n.bitn = r.bitn + 4'h1;
              if (r.bitn == 4'h7) n.st = m_ack;
            end
            default: n.sda = r.sda;
          endcase
        end
        m_ack: begin
          // ack read bytes only if asked
          case (r.q)
            2'h0: n.sda = r.rd ? ~r.ack_c : 1'b1;
            2'h1: n.scl = 1'b1;
            2'h2: n.nack = r.rd ? 1'b0 : r.sda_s[1];
            2'h3: begin
              n.scl = 1'b0;
              n.st = r.do_stop ? m_stop : m_idle;
              n.busy = r.do_stop;
            end
            default: n.sda = r.sda;
          endcase
        end
        m_stop: begin
          case (r.q)
            2'h0: n.sda = 1'b0;
            2'h1: n.scl = 1'b1;
            2'h2: n.sda = 1'b1;
            2'h3: begin
              n.st = m_idle;
              n.busy = 1'b0;
            end
            default: n.sda = r.sda;
          endcase
        end
        default: n.st = m_idle;
      endcase
    end
  end

  // state register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      r <= '0;
      r.st <= m_idle;
      r.scl <= 1'b1;
      r.sda <= 1'b1;
      r.sda_s <= 2'h3;
    end else begin
      r <= n;
    end
  end
  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = 1'b0;
  assign bus.scl_o = 1'b0;
  assign bus.scl_oe = ~r.scl;
  assign bus.sda_m_o = 1'b0;
  assign bus.sda_m_oe = ~r.sda;
endmodule : lcd_i2c_master

// file: tb/lcd_driver_i2c_props.sv
// checker for the two-wire link between the display driver and its master
module lcd_driver_i2c_props (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_s_o,
  input wire logic sda_s_oe,
  input wire logic address_select_pin,
  input wire logic [6:0] x_ptr,
  input wire logic [3:0] y_ptr
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================================
  // bus observer: bit count, shifter and transfer flags
  logic scl_q, sda_q, first, sel, rd, foreign, nacked;
  logic [3:0] cnt;
  logic [7:0] sh;
  wire start_c = scl_q & scl & sda_q & ~sda;
  wire stop_c = scl_q & scl & ~sda_q & sda;
  wire rise = ~scl_q & scl;
  wire hit = (sh[7:1] == {lcd_i2c_pkg::addr_hi, address_select_pin});
  // cnt 8 marks the acknowledge slot of each byte
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      cnt <= 4'h0;
      sh <= 8'h00;
      first <= 1'b0;
      sel <= 1'b0;
      rd <= 1'b0;
      foreign <= 1'b0;
      nacked <= 1'b0;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (start_c || stop_c) begin
        cnt <= 4'h0;
        first <= start_c;
        sel <= 1'b0;
        rd <= 1'b0;
        foreign <= 1'b0;
        nacked <= 1'b0;
      end else if (rise) begin
        cnt <= (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
        if (cnt != 4'h8) begin
          sh <= {sh[6:0], sda};
        end else if (first) begin
          first <= 1'b0;
          sel <= hit & ~sh[0];
          rd <= hit & sh[0];
          foreign <= ~hit;
        end else if (rd && sda) begin
          nacked <= 1'b1;
        end
      end
    end
  end
  // ==========================================================================
  // properties
  default clocking cb_main @(posedge clk); endclocking
  default disable iff (!arst_n);
  ptr_range_a: assert property (x_ptr <= lcd_i2c_pkg::x_last && y_ptr <= lcd_i2c_pkg::y_last)
    else $error("pointer out of range");
  wrap_both_a: assert property ($past(x_ptr) == lcd_i2c_pkg::x_last
    && $past(y_ptr) == lcd_i2c_pkg::y_last && $changed(x_ptr) && $changed(y_ptr)
    |-> x_ptr == 7'h00 && y_ptr == 4'h0) else $error("last cell did not wrap to zero");
  ptr_timing_a: assert property ($changed(x_ptr) || $changed(y_ptr) |-> cnt == 4'h8)
    else $error("pointer moved outside acknowledge slot");
  drive_stable_a: assert property (scl && $past(scl) |-> $stable(sda_s_oe))
    else $error("slave changed sda while scl high");
  addr_ack_a: assert property (rise && cnt == 4'h8 && first && hit && !sh[0]
    |-> sda_s_oe && !sda) else $error("own address not acknowledged");
  data_ack_a: assert property (rise && cnt == 4'h8 && !first && sel
    |-> sda_s_oe && !sda_s_o) else $error("written byte not acknowledged");
  foreign_quiet_a: assert property (foreign |-> !sda_s_oe)
    else $error("slave drives during foreign transfer");
  nack_quiet_a: assert property (nacked |-> !sda_s_oe)
    else $error("slave drives after master withheld ack");
  addr_cov: cover property (rise && cnt == 4'h8 && first && hit);
  foreign_cov: cover property (foreign);
  nack_cov: cover property (nacked);
  wrap_cov: cover property (x_ptr == 7'h00 && $past(x_ptr) == lcd_i2c_pkg::x_last);
endmodule : lcd_driver_i2c_props

// file: tb/test_lcd_driver_i2c_ram_addressing.sv
// testbench: apb driven master against the display driver slave
module test_lcd_driver_i2c_ram_addressing;
  timeunit 1ns;
  timeprecision 1ns;
  typedef logic [7:0] bytes_t[$];
  logic clk, arst_n, psel, penable, pwrite, pready, address_select_pin;
  logic [7:0] paddr, rd_byte, status_byte;
  logic [31:0] pwdata, prdata, q;
  logic [6:0] rd_col, x_ptr;
  logic [3:0] rd_bank, y_ptr;
  int failures, n_compared, cycles;
  lcd_i2c_if bus ();
  lcd_driver_i2c i_lcd_driver_i2c (.clk(clk), .arst_n(arst_n), .bus(bus),
    .address_select_pin(address_select_pin), .rd_col(rd_col), .rd_bank(rd_bank),
    .rd_byte(rd_byte), .status_byte(status_byte), .x_ptr(x_ptr), .y_ptr(y_ptr));
  lcd_i2c_master i_lcd_i2c_master (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(), .bus(bus));
  lcd_driver_i2c_props i_lcd_driver_i2c_props (.clk(clk), .arst_n(arst_n), .scl(bus.scl),
    .sda(bus.sda), .sda_s_o(bus.sda_s_o), .sda_s_oe(bus.sda_s_oe),
    .address_select_pin(address_select_pin), .x_ptr(x_ptr), .y_ptr(y_ptr));
  // ==========================================================================
  // helpers
  task final_report;
    if (failures == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report
  task check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // one apb transfer, held until pready is seen high
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // polled, not timed: the bus byte length is the master's business
  task wait_idle;
    do apb(1'b0, lcd_i2c_pkg::reg_stat, 32'h0); while (q[0] !== 1'b0);
  endtask : wait_idle
  task put(input logic [7:0] b, input logic s, input logic p, input logic nack);
    apb(1'b1, lcd_i2c_pkg::reg_txd, {24'h0, b});
    apb(1'b1, lcd_i2c_pkg::reg_ctrl, {28'h0, s, p, 2'b01});
    wait_idle();
    check({7'h0, q[1]}, {7'h0, nack});
  endtask : put
  task frame(input bytes_t b);
    for (int i = 0; i < b.size(); i++) begin
      put(b[i], i == 0, i == b.size() - 1, 1'b0);
    end
  endtask : frame
  task ptrs(input logic [6:0] x, input logic [3:0] y);
    check({1'b0, x_ptr}, {1'b0, x});
    check({4'h0, y_ptr}, {4'h0, y});
  endtask : ptrs
  // ram read port is registered, so allow the byte to land
  task ram(input logic [6:0] col, input logic [3:0] bank, input logic [7:0] exp);
    rd_col <= col;
    rd_bank <= bank;
    repeat (3) @(posedge clk);
    check(rd_byte, exp);
  endtask : ram
  // ==========================================================================
  // scenarios
  task t_address;
    put(8'h7e, 1'b1, 1'b1, 1'b1);
    put(8'h7a, 1'b1, 1'b1, 1'b1);
    address_select_pin <= 1'b1;
    put(8'h7a, 1'b1, 1'b1, 1'b0);
    address_select_pin <= 1'b0;
  endtask : t_address
  task t_horizontal;
    frame('{8'h78, 8'h00, 8'h0d, 8'he5, 8'h42});
    frame('{8'h78, 8'h40, 8'ha5});
    ptrs(7'h00, 4'h3);
    ram(7'h65, 4'h2, 8'ha5);
  endtask : t_horizontal
  task t_vertical;
    frame('{8'h78, 8'h80, 8'h22, 8'h80, 8'he5, 8'h00, 8'h47});
    frame('{8'h78, 8'h40, 8'h3c, 8'h81});
    ptrs(7'h00, 4'h0);
    ram(7'h65, 4'h7, 8'h3c);
  endtask : t_vertical
  task t_mirror;
    frame('{8'h78, 8'h00, 8'h21, 8'h0f, 8'h3a, 8'h80, 8'h48});
    put(8'h79, 1'b1, 1'b0, 1'b0);
    apb(1'b1, lcd_i2c_pkg::reg_ackc, 32'h0);
    apb(1'b1, lcd_i2c_pkg::reg_ctrl, 32'h7);
    wait_idle();
    apb(1'b0, lcd_i2c_pkg::reg_rxd, 32'h0);
    check(q[7:0], 8'h7f);
    check(status_byte, 8'h7f);
    address_select_pin <= 1'b1;
    frame('{8'h7a, 8'h40, 8'h01});
    ptrs(7'h01, 4'h0);
    ram(7'h65, 4'h8, 8'h80);
  endtask : t_mirror
  // ==========================================================================
  // clock, hang guard and main sequence
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // about 35 bus bytes of some 2300 cycles each
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 99000) begin
      failures++;
      final_report();
    end
  end
  initial begin
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    address_select_pin = 1'b0;
    rd_col = 7'h00;
    rd_bank = 4'h0;
    failures = 0;
    n_compared = 0;
    cycles = 0;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    t_address();
    t_horizontal();
    t_vertical();
    t_mirror();
    final_report();
  end
endmodule : test_lcd_driver_i2c_ram_addressing
